//--- rtl/e1_status_pkg.sv
// constants for the e1 framer status and alarm register bank
package e1_status_pkg;
   localparam logic [7:0] ADDR_ALARM_ONE = 8'h06;
   localparam logic [7:0] ADDR_RX_INFO = 8'h08;
   localparam logic [7:0] ADDR_SYNC_STATUS = 8'h1e;
   // receive information bit positions
   localparam int INFO_TX_FULL = 7;
   localparam int INFO_TX_EMPTY = 6;
   localparam int INFO_CLK_LOST = 5;
   localparam int INFO_RX_FULL = 4;
   localparam int INFO_RX_EMPTY = 3;
   localparam int INFO_CRC_RESYNC = 2;
   localparam int INFO_FAS_RESYNC = 1;
   localparam int INFO_CAS_RESYNC = 0;
   // alarm register bit positions
   localparam int ALM_SIG_ONES = 7;
   localparam int ALM_DISTANT = 6;
   localparam int ALM_SIG_ZEROS = 5;
   localparam int ALM_SLIP = 4;
   localparam int ALM_UNFRAMED = 3;
   localparam int ALM_REMOTE = 2;
   localparam int ALM_CARRIER = 1;
   localparam int ALM_LOS = 0;
   localparam int DMA_BIT_POS = 2;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   // timing
   localparam int CLK_PERIOD_NS = 20;
   localparam int RX_CLK_LOST_NS = 2000;
   localparam int RX_CLK_LOST_CYC = (RX_CLK_LOST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // resync criteria counts
   localparam logic [9:0] CRC_WINDOW_WORDS = 10'd1000;
   localparam logic [9:0] CRC_ERR_LIMIT = 10'd915;
   localparam logic [1:0] FAS_ERR_RUN = 2'd3;
   localparam logic [1:0] CAS_ERR_RUN = 2'd2;
   localparam logic [7:0] SIG_ONES_MIN_ZEROS = 8'd3;
   // carrier loss counts
   localparam logic [11:0] CL_SHORT_ZEROS = 12'd255;
   localparam logic [11:0] CL_LONG_ZEROS = 12'd2048;
   localparam logic [7:0] CL_CLEAR_WINDOW = 8'd255;
   localparam logic [5:0] CL_CLEAR_ONES = 6'd32;
endpackage : e1_status_pkg

//--- rtl/e1_framer_status_alarm_regs.sv
// status, synchronizer and alarm registers of one e1 framer
`timescale 1ns/1ns
`default_nettype none
module e1_framer_status_alarm_regs
(
   input wire logic clk_i, // 50 MHz system clock
   input wire logic rstn_i, // async reset, active low
   input wire logic [7:0] addr_i, // register address
   input wire logic wr_i, // write strobe
   input wire logic rd_i, // read strobe
   input wire logic [7:0] wdata_i, // write data
   output logic [7:0] rdata_o, // read data, valid cycle after rd_i
   output logic int_n_o, // interrupt, active low
   input wire logic rx_line_clk_i, // receive line clock pin
   input wire logic rx_positive_rail_i, // receive positive rail pin
   input wire logic rx_negative_rail_i, // receive negative rail pin
   input wire logic tx_elastic_full_i, // pulse: tx store frame deleted
   input wire logic tx_elastic_empty_i, // pulse: tx store frame repeated
   input wire logic rx_elastic_full_i, // pulse: rx store frame deleted
   input wire logic rx_elastic_empty_i, // pulse: rx store frame repeated
   input wire logic crc_word_i, // pulse: crc code word checked
   input wire logic crc_word_err_i, // with crc_word_i: word errored
   input wire logic fas_word_i, // pulse: fas word checked
   input wire logic fas_word_err_i, // with fas_word_i: word errored
   input wire logic cas_word_i, // pulse: cas mf word checked
   input wire logic cas_word_err_i, // with cas_word_i: word errored
   input wire logic ts16_valid_i, // pulse: timeslot 16 byte present
   input wire logic [3:0] ts16_frame_i, // frame number in multiframe
   input wire logic [7:0] ts16_byte_i, // timeslot 16 content
   input wire logic unframed_ones_i, // level: unframed all ones seen
   input wire logic remote_alarm_i, // level: remote alarm seen
   input wire logic frame_aligned_i, // level: framer aligned
   input wire logic crc4_timeout_i, // pulse: 8ms crc4 search expired
   input wire logic crc4_sync_i, // pulse: crc4 multiframe sync found
   input wire logic crc4_mode_enable_i, // crc4 mode enable control
   input wire logic carrier_loss_long_count_select_i, // 2048 zero count
   input wire logic fas_search_active_i, // searching fas
   input wire logic cas_mf_search_active_i, // searching cas mf word
   input wire logic crc4_mf_search_active_i // searching crc4 mf word
);
   import e1_status_pkg::*;

   typedef struct packed {
      logic [2:0] sync_clk;
      logic [2:0] sync_pos;
      logic [2:0] sync_neg;
      logic clk_level;
      logic [7:0] quiet_cnt;
      logic [9:0] crc_words;
      logic [9:0] crc_errs;
      logic [1:0] fas_run;
      logic [1:0] cas_run;
      logic [11:0] zero_run;
      logic [7:0] cl_win;
      logic [5:0] cl_ones;
      logic carrier_lost;
      logic [7:0] mf_zeros;
      logic mf_ones;
      logic mf_change;
      logic [15:0][7:0] sig_prev;
      logic sig_ones;
      logic sig_zeros;
      logic dma_prev;
      logic distant;
      logic [5:0] search_cnt;
      logic [7:0] alarm_latch;
      logic [7:0] info_latch;
      logic [7:0] alarm_read;
      logic [7:0] info_read;
      logic [7:0] alarm_armed;
      logic [7:0] info_armed;
      logic [7:0] pending;
      logic [7:0] alarm_prev;
      logic [7:0] rdata;
   } state_t;

   state_t s;
   state_t next_s;

   function automatic logic [3:0] ones_in(input logic [7:0] b);
      logic [3:0] c;
      c = 4'd0;
      for (int i = 0; i < 8; i++)
      begin
         c = c + {3'd0, b[i]};
      end
      return c;
   endfunction : ones_in

   logic [7:0] set_info;
   logic [7:0] set_alarm;
   logic [7:0] sync_view;
   logic bit_tick;
   logic bit_zero;
   logic clk_lost_now;
   logic crc_resync;
   logic fas_resync;
   logic cas_resync;
   logic sig_change_now;
   logic [7:0] mf_zeros_sum;
   logic [9:0] crc_words_sum;
   logic [9:0] crc_errs_sum;
   logic [11:0] cl_limit;
   logic wr_alarm;
   logic wr_info;

   always_comb
   begin
      next_s = s;
      // pin inputs pass three flops
      next_s.sync_clk = {s.sync_clk[1:0], rx_line_clk_i};
      next_s.sync_pos = {s.sync_pos[1:0], rx_positive_rail_i};
      next_s.sync_neg = {s.sync_neg[1:0], rx_negative_rail_i};
      bit_tick = 1'b0;
      // idle receive clock watchdog
      clk_lost_now = 1'b0;
      if (s.sync_clk[2] == s.sync_clk[1] && s.sync_clk[2] != s.clk_level)
      begin
         next_s.clk_level = s.sync_clk[2];
         bit_tick = s.sync_clk[2];
         next_s.quiet_cnt = 8'd0;
      end
      else if (s.quiet_cnt == 8'(RX_CLK_LOST_CYC - 1))
      begin
         clk_lost_now = 1'b1;
      end
      else
      begin
         next_s.quiet_cnt = s.quiet_cnt + 8'd1;
      end
      // crc word error ratio window
      crc_resync = 1'b0;
      crc_words_sum = s.crc_words + {9'd0, crc_word_i};
      crc_errs_sum = s.crc_errs + {9'd0, crc_word_i & crc_word_err_i};
      next_s.crc_words = crc_words_sum;
      next_s.crc_errs = crc_errs_sum;
      if (crc_errs_sum >= CRC_ERR_LIMIT)
      begin
         crc_resync = 1'b1;
         next_s.crc_words = 10'd0;
         next_s.crc_errs = 10'd0;
      end
      else if (crc_words_sum >= CRC_WINDOW_WORDS)
      begin
         next_s.crc_words = 10'd0;
         next_s.crc_errs = 10'd0;
      end
      // consecutive alignment word errors
      fas_resync = 1'b0;
      if (fas_word_i)
      begin
         next_s.fas_run = fas_word_err_i ? s.fas_run + 2'd1 : 2'd0;
         if (fas_word_err_i && s.fas_run == FAS_ERR_RUN - 2'd1)
         begin
            fas_resync = 1'b1;
            next_s.fas_run = 2'd0;
         end
      end
      cas_resync = 1'b0;
      if (cas_word_i)
      begin
         next_s.cas_run = cas_word_err_i ? s.cas_run + 2'd1 : 2'd0;
         if (cas_word_err_i && s.cas_run == CAS_ERR_RUN - 2'd1)
         begin
            cas_resync = 1'b1;
            next_s.cas_run = 2'd0;
         end
      end
      // carrier loss on the rails
      bit_zero = ~s.sync_pos[2] & ~s.sync_neg[2];
      cl_limit = carrier_loss_long_count_select_i ? CL_LONG_ZEROS : CL_SHORT_ZEROS;
      if (bit_tick)
      begin
         next_s.zero_run = bit_zero ? s.zero_run + 12'd1 : 12'd0;
         if (bit_zero && s.zero_run + 12'd1 >= cl_limit)
         begin
            next_s.carrier_lost = 1'b1;
            next_s.zero_run = cl_limit;
         end
         next_s.cl_win = s.cl_win + 8'd1;
         next_s.cl_ones = s.cl_ones + {5'd0, ~bit_zero & (s.cl_ones != CL_CLEAR_ONES)};
         if (s.cl_win + 8'd1 == CL_CLEAR_WINDOW)
         begin
            next_s.cl_win = 8'd0;
            next_s.cl_ones = 6'd0;
         end
         if (next_s.cl_ones == CL_CLEAR_ONES && !(bit_zero && next_s.carrier_lost && !s.carrier_lost))
         begin
            next_s.carrier_lost = 1'b0;
         end
      end
      // timeslot 16 multiframe checks
      sig_change_now = 1'b0;
      mf_zeros_sum = s.mf_zeros + 8'(4'd8 - ones_in(ts16_byte_i));
      if (ts16_valid_i)
      begin
         next_s.mf_zeros = mf_zeros_sum;
         next_s.mf_ones = s.mf_ones | (|ts16_byte_i);
         next_s.sig_prev[ts16_frame_i] = ts16_byte_i;
         if (ts16_frame_i != 4'd0 && s.sig_prev[ts16_frame_i] != ts16_byte_i)
         begin
            next_s.mf_change = 1'b1;
         end
         if (ts16_frame_i == 4'd0)
         begin
            next_s.dma_prev = ts16_byte_i[DMA_BIT_POS];
            if (ts16_byte_i[DMA_BIT_POS] == s.dma_prev)
            begin
               next_s.distant = s.dma_prev;
            end
         end
         if (ts16_frame_i == 4'hf)
         begin
            next_s.sig_ones = mf_zeros_sum < SIG_ONES_MIN_ZEROS;
            next_s.sig_zeros = ~next_s.mf_ones;
            sig_change_now = next_s.mf_change;
            next_s.mf_zeros = 8'd0;
            next_s.mf_ones = 1'b0;
            next_s.mf_change = 1'b0;
         end
      end
      // crc4 search counter
      if (!crc4_mode_enable_i || crc4_sync_i)
      begin
         next_s.search_cnt = 6'd0;
      end
      else if (crc4_timeout_i)
      begin
         next_s.search_cnt = s.search_cnt + 6'd1;
      end
      // latched set terms
      set_info = RESET_BYTE;
      set_info[INFO_TX_FULL] = tx_elastic_full_i;
      set_info[INFO_TX_EMPTY] = tx_elastic_empty_i;
      set_info[INFO_CLK_LOST] = clk_lost_now;
      set_info[INFO_RX_FULL] = rx_elastic_full_i;
      set_info[INFO_RX_EMPTY] = rx_elastic_empty_i;
      set_info[INFO_CRC_RESYNC] = crc_resync;
      set_info[INFO_FAS_RESYNC] = fas_resync;
      set_info[INFO_CAS_RESYNC] = cas_resync;
      set_alarm = RESET_BYTE;
      set_alarm[ALM_SIG_ONES] = s.sig_ones | sig_change_now;
      set_alarm[ALM_DISTANT] = s.distant;
      set_alarm[ALM_SIG_ZEROS] = s.sig_zeros | sig_change_now;
      set_alarm[ALM_SLIP] = rx_elastic_full_i | rx_elastic_empty_i;
      set_alarm[ALM_UNFRAMED] = unframed_ones_i;
      set_alarm[ALM_REMOTE] = remote_alarm_i;
      set_alarm[ALM_CARRIER] = s.carrier_lost;
      set_alarm[ALM_LOS] = ~frame_aligned_i;
      // write-read-write access; a new set beats the clear
      wr_alarm = wr_i && addr_i == ADDR_ALARM_ONE;
      wr_info = wr_i && addr_i == ADDR_RX_INFO;
      next_s.alarm_latch = (s.alarm_latch & ~(wr_alarm ? wdata_i & s.alarm_armed : 8'h00))
         | set_alarm;
      next_s.info_latch = (s.info_latch & ~(wr_info ? wdata_i & s.info_armed : 8'h00))
         | set_info;
      if (wr_alarm)
      begin
         next_s.alarm_read = (wdata_i & next_s.alarm_latch) | (~wdata_i & s.alarm_read);
         next_s.alarm_armed = 8'h00;
      end
      if (wr_info)
      begin
         next_s.info_read = (wdata_i & next_s.info_latch) | (~wdata_i & s.info_read);
         next_s.info_armed = 8'h00;
      end
      // interrupt requests: alarm bits 7:4 on set, alarm bits 3:0 on any change; info events raise none
      next_s.alarm_prev = set_alarm;
      sync_view = {s.search_cnt[5:2], s.search_cnt[0], fas_search_active_i,
         cas_mf_search_active_i, crc4_mf_search_active_i};
      if (rd_i)
      begin
         if (addr_i == ADDR_ALARM_ONE)
         begin
            next_s.rdata = s.alarm_read;
            next_s.alarm_armed = s.alarm_read;
            next_s.pending = s.pending & ~s.alarm_read;
         end
         else if (addr_i == ADDR_RX_INFO)
         begin
            next_s.rdata = s.info_read;
            next_s.info_armed = s.info_read;
         end
         else if (addr_i == ADDR_SYNC_STATUS)
         begin
            next_s.rdata = sync_view;
         end
         else
         begin
            next_s.rdata = RESET_BYTE;
         end
      end
      next_s.pending = next_s.pending
         | {set_alarm[7:4] & ~s.alarm_prev[7:4], set_alarm[3:0] ^ s.alarm_prev[3:0]};
   end

   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         s <= '0;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign rdata_o = s.rdata;
   assign int_n_o = ~(|s.pending);

   // checks
   clk_lost_set_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      s.quiet_cnt == 8'(RX_CLK_LOST_CYC - 1) && s.sync_clk[2] == s.clk_level
      |=> s.info_latch[INFO_CLK_LOST]) else $error("clock loss flag not set");
   tx_full_set_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      tx_elastic_full_i |=> s.info_latch[INFO_TX_FULL] [*2])
      else $error("tx full flag not held");
   fas_resync_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      fas_word_i && fas_word_err_i && s.fas_run == 2'd2 |=> s.info_latch[INFO_FAS_RESYNC])
      else $error("fas resync flag missing");
   search_clear_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      !crc4_mode_enable_i |=> s.search_cnt == 6'd0) else $error("search count not cleared");
   search_step_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      crc4_mode_enable_i && !crc4_sync_i && crc4_timeout_i
      |=> s.search_cnt == $past(s.search_cnt) + 6'd1) else $error("search count not stepped");
   sync_read_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      rd_i && addr_i == ADDR_SYNC_STATUS
      |=> rdata_o[7:3] == {$past(s.search_cnt[5:2]), $past(s.search_cnt[0])})
      else $error("sync status read wrong");
   los_hold_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      !frame_aligned_i |=> s.alarm_latch[ALM_LOS]) else $error("loss of sync not latched");
   slip_int_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      rx_elastic_full_i && !s.alarm_prev[ALM_SLIP] |=> !int_n_o)
      else $error("slip interrupt missing");
   latch_keep_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      s.info_latch[INFO_CAS_RESYNC] && !wr_i |=> s.info_latch[INFO_CAS_RESYNC])
      else $error("latched bit lost without write");
   mask_hold_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
      wr_i && addr_i == ADDR_RX_INFO && !wdata_i[0] |=> s.info_read[0] == $past(s.info_read[0]))
      else $error("unmasked bit refreshed");
endmodule : e1_framer_status_alarm_regs
`default_nettype wire

//--- bench/e1_host_model.sv
// host processor model on the parallel register port
`timescale 1ns/1ns
`default_nettype none
module e1_host_model (
   input wire logic clk_i, // system clock
   output logic [7:0] addr_o, // register address
   output logic wr_o, // write strobe
   output logic rd_o, // read strobe
   output logic [7:0] wdata_o, // write data
   input wire logic [7:0] rdata_i // read data
);
   initial
   begin
      addr_o = 8'h00;
      wr_o = 1'b0;
      rd_o = 1'b0;
      wdata_o = 8'h00;
   end
   task automatic write(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_o <= a;
      wdata_o <= d;
      wr_o <= 1'b1;
      @(posedge clk_i);
      wr_o <= 1'b0;
      // released data no longer shows the last value
      wdata_o <= ~d;
      @(negedge clk_i);
   endtask : write
   task automatic read(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i);
      addr_o <= a;
      rd_o <= 1'b1;
      @(posedge clk_i);
      rd_o <= 1'b0;
      @(negedge clk_i);
      d = rdata_i;
   endtask : read
   // mask write, read, write back read value and mask
   task automatic poll(input logic [7:0] a, input logic [7:0] m, output logic [7:0] d);
      write(a, m);
      read(a, d);
      write(a, d & m);
   endtask : poll
endmodule : e1_host_model
`default_nettype wire

//--- bench/e1_framer_status_alarm_regs_test.sv
// self-checking bench for the e1 framer status and alarm registers
`timescale 1ns/1ns
`default_nettype none
`define CHECK(got, exp) \
   begin \
      tests_run++; \
      if ((got) !== (exp)) \
      begin \
         err_total++; \
         $display("FAIL %0t: got %h expected %h", $time, got, exp); \
      end \
   end
module e1_framer_status_alarm_regs_test;
   import e1_status_pkg::*;
   typedef struct packed {
      logic [9:0] ev;
      logic [9:0] reps;
      logic [7:0] addr;
      logic [7:0] mask;
      logic [7:0] exp;
   } row_t;
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic [7:0] addr, wdata, rdata_o, d;
   logic wr, rd, int_n_o;
   logic line_clk = 1'b0;
   logic line_run = 1'b0;
   logic rail = 1'b0;
   logic [1:0] ph = 2'd0;
   logic [9:0] ev_q = 10'h000;
   logic [2:0] lvl = 3'b000;
   logic [2:0] srch = 3'b000;
   logic crc_en = 1'b1;
   logic long_sel = 1'b0;
   logic ts_valid = 1'b0;
   logic [3:0] ts_frame = 4'h0;
   logic [7:0] ts_byte = 8'h00;
   logic [7:0] lmask [3] = '{8'h01, 8'h04, 8'h08};
   int err_total = 0;
   int tests_run = 0;
   int cycles = 0;
   // event bits: tx full, tx empty, rx full, rx empty, fas err, cas err,
   // crc4 timeout, crc4 sync, crc word good, crc word errored
   row_t rows [17] = '{
      '{10'h001, 10'd1, ADDR_RX_INFO, 8'h80, 8'h80},
      '{10'h002, 10'd1, ADDR_RX_INFO, 8'h40, 8'h40},
      '{10'h004, 10'd1, ADDR_RX_INFO, 8'h10, 8'h10},
      '{10'h008, 10'd1, ADDR_RX_INFO, 8'h08, 8'h08},
      '{10'h004, 10'd1, ADDR_ALARM_ONE, 8'h10, 8'h10},
      '{10'h010, 10'd2, ADDR_RX_INFO, 8'h02, 8'h00},
      '{10'h010, 10'd1, ADDR_RX_INFO, 8'h02, 8'h02},
      '{10'h020, 10'd1, ADDR_RX_INFO, 8'h01, 8'h00},
      '{10'h020, 10'd1, ADDR_RX_INFO, 8'h01, 8'h01},
      '{10'h040, 10'd5, ADDR_SYNC_STATUS, 8'h00, 8'h18},
      '{10'h040, 10'd58, ADDR_SYNC_STATUS, 8'h00, 8'hf8},
      '{10'h040, 10'd1, ADDR_SYNC_STATUS, 8'h00, 8'h00},
      '{10'h040, 10'd3, ADDR_SYNC_STATUS, 8'h00, 8'h08},
      '{10'h080, 10'd1, ADDR_SYNC_STATUS, 8'h00, 8'h00},
      '{10'h100, 10'd85, ADDR_RX_INFO, 8'h04, 8'h00},
      '{10'h200, 10'd914, ADDR_RX_INFO, 8'h04, 8'h00},
      '{10'h200, 10'd1, ADDR_RX_INFO, 8'h04, 8'h04}
   };

   always #10 clk_i = ~clk_i;

   e1_host_model i_e1_host_model (
      .clk_i(clk_i), .addr_o(addr), .wr_o(wr), .rd_o(rd), .wdata_o(wdata), .rdata_i(rdata_o)
   );

   e1_framer_status_alarm_regs i_e1_framer_status_alarm_regs (
      .clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr), .wr_i(wr), .rd_i(rd),
      .wdata_i(wdata), .rdata_o(rdata_o), .int_n_o(int_n_o),
      .rx_line_clk_i(line_clk), .rx_positive_rail_i(rail), .rx_negative_rail_i(1'b0),
      .tx_elastic_full_i(ev_q[0]), .tx_elastic_empty_i(ev_q[1]),
      .rx_elastic_full_i(ev_q[2]), .rx_elastic_empty_i(ev_q[3]),
      .crc_word_i(ev_q[8] | ev_q[9]), .crc_word_err_i(ev_q[9]),
      .fas_word_i(ev_q[4]), .fas_word_err_i(ev_q[4]),
      .cas_word_i(ev_q[5]), .cas_word_err_i(ev_q[5]),
      .ts16_valid_i(ts_valid), .ts16_frame_i(ts_frame), .ts16_byte_i(ts_byte),
      .unframed_ones_i(lvl[2]), .remote_alarm_i(lvl[1]), .frame_aligned_i(~lvl[0]),
      .crc4_timeout_i(ev_q[6]), .crc4_sync_i(ev_q[7]), .crc4_mode_enable_i(crc_en),
      .carrier_loss_long_count_select_i(long_sel),
      .fas_search_active_i(srch[2]), .cas_mf_search_active_i(srch[1]),
      .crc4_mf_search_active_i(srch[0])
   );

   // line clock: 8 system cycles a bit, stands still when stopped
   always @(posedge clk_i)
   begin
      if (line_run)
      begin
         ph <= ph + 2'd1;
         if (ph == 2'd3)
            line_clk <= ~line_clk;
      end
   end

   task automatic final_report();
      $display("checks %0d errors %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : final_report

   always @(posedge clk_i)
   begin
      cycles <= cycles + 1;
      if (cycles == 12000)
      begin
         err_total++;
         final_report();
      end
   end

   task automatic pulse(input logic [9:0] ev);
      @(posedge clk_i);
      ev_q <= ev;
      @(posedge clk_i);
      ev_q <= 10'h000;
   endtask : pulse

   task automatic send_mf(input logic [7:0] b);
      for (int f = 0; f < 16; f++)
      begin
         @(posedge clk_i);
         ts_valid <= 1'b1;
         ts_frame <= f[3:0];
         ts_byte <= b;
         @(posedge clk_i);
         ts_valid <= 1'b0;
      end
   endtask : send_mf

   task automatic reg_poll(input logic [7:0] a, input logic [7:0] m);
      i_e1_host_model.poll(a, m, d);
   endtask : reg_poll

   initial
   begin
      repeat (4) @(posedge clk_i);
      `CHECK(rdata_o, 8'h00)
      `CHECK(int_n_o, 1'b1)
      rstn_i <= 1'b1;
      foreach (rows[i])
      begin
         repeat (rows[i].reps)
            pulse(rows[i].ev);
         if (rows[i].addr == ADDR_SYNC_STATUS)
            i_e1_host_model.read(rows[i].addr, d);
         else
            reg_poll(rows[i].addr, rows[i].mask);
         `CHECK(d, rows[i].exp)
      end
      // live search bits, write to the read-only register ignored
      @(posedge clk_i);
      srch <= 3'b101;
      i_e1_host_model.write(ADDR_SYNC_STATUS, 8'hff);
      i_e1_host_model.read(ADDR_SYNC_STATUS, d);
      `CHECK(d, 8'h05)
      repeat (3)
         pulse(10'h040);
      @(posedge clk_i);
      crc_en <= 1'b0;
      @(posedge clk_i);
      crc_en <= 1'b1;
      i_e1_host_model.read(ADDR_SYNC_STATUS, d);
      `CHECK(d, 8'h05)
      i_e1_host_model.read(8'h55, d);
      `CHECK(d, 8'h00)
      // loss of sync, remote and unframed alarms with interrupt
      foreach (lmask[k])
      begin
         @(posedge clk_i);
         lvl <= 3'b001 << k;
         repeat (4) @(negedge clk_i);
         `CHECK(int_n_o, 1'b0)
         reg_poll(ADDR_ALARM_ONE, lmask[k]);
         `CHECK(d, lmask[k])
         `CHECK(int_n_o, 1'b1)
         reg_poll(ADDR_ALARM_ONE, lmask[k]);
         `CHECK(d, lmask[k])
         @(posedge clk_i);
         lvl <= 3'b000;
         repeat (4) @(negedge clk_i);
         `CHECK(int_n_o, 1'b0)
         reg_poll(ADDR_ALARM_ONE, lmask[k]);
         reg_poll(ADDR_ALARM_ONE, lmask[k]);
         `CHECK(d, 8'h00)
      end
      // zeros on the rails: 300 bits pass the short count only
      @(posedge clk_i);
      long_sel <= 1'b1;
      line_run <= 1'b1;
      repeat (2400) @(posedge clk_i);
      reg_poll(ADDR_ALARM_ONE, 8'h02);
      `CHECK(d, 8'h00)
      reg_poll(ADDR_RX_INFO, 8'h20);
      reg_poll(ADDR_RX_INFO, 8'h20);
      `CHECK(d, 8'h00)
      @(posedge clk_i);
      long_sel <= 1'b0;
      repeat (40) @(posedge clk_i);
      reg_poll(ADDR_ALARM_ONE, 8'h02);
      `CHECK(d, 8'h02)
      @(posedge clk_i);
      line_run <= 1'b0;
      repeat (120) @(posedge clk_i);
      reg_poll(ADDR_RX_INFO, 8'h20);
      `CHECK(d, 8'h20)
      // ones on the rail end carrier loss
      @(posedge clk_i);
      rail <= 1'b1;
      line_run <= 1'b1;
      repeat (700) @(posedge clk_i);
      @(negedge clk_i);
      `CHECK(int_n_o, 1'b0)
      reg_poll(ADDR_ALARM_ONE, 8'h02);
      reg_poll(ADDR_ALARM_ONE, 8'h02);
      `CHECK(d, 8'h00)
      send_mf(8'h00);
      send_mf(8'h00);
      reg_poll(ADDR_ALARM_ONE, 8'ha0);
      `CHECK(d, 8'h20)
      send_mf(8'hff);
      send_mf(8'hff);
      reg_poll(ADDR_ALARM_ONE, 8'he0);
      `CHECK(d, 8'he0)
      // a signaling change alone sets the all-ones and all-zeros bits
      send_mf(8'h0f);
      reg_poll(ADDR_ALARM_ONE, 8'he0);
      `CHECK(d, 8'he0)
      send_mf(8'h0f);
      reg_poll(ADDR_ALARM_ONE, 8'he0);
      `CHECK(d, 8'h40)
      // reset in mid-run clears counter and read data
      pulse(10'h040);
      @(posedge clk_i);
      rstn_i <= 1'b0;
      @(negedge clk_i);
      `CHECK(rdata_o, 8'h00)
      `CHECK(int_n_o, 1'b1)
      @(posedge clk_i);
      rstn_i <= 1'b1;
      i_e1_host_model.read(ADDR_SYNC_STATUS, d);
      `CHECK(d, 8'h05)
      final_report();
   end
endmodule : e1_framer_status_alarm_regs_test
`default_nettype wire
